// File: hw/omc_defines.vh
// Constants of the operating mode controller
`ifndef OMC_DEFINES_VH
`define OMC_DEFINES_VH
// Register write field positions
`define OMC_BIT_STOP 1
`define OMC_BIT_SLOW 2
`define OMC_BIT_SLEEP 3
`define OMC_BIT_GREEN 4
// Mode field codes
`define OMC_MODE_NORMAL 2'h0
`define OMC_MODE_SLEEP 2'h1
`define OMC_MODE_GREEN 2'h2
`define OMC_MODE_RSVD 2'h3
// Reset value of the control register
`define OMC_REG_RESET 8'h00
// Wake-up warm-up counts in high-speed clocks
`define OMC_WARM_XTAL 2048
`define OMC_WARM_RC 8
// Slow mode instruction clock divide
`define OMC_SLOW_DIV 4
`endif

// File: hw/omc_ctrl.v
// Operating mode controller: mode sequencing and clock gating
`timescale 1ns/10ps
`include "omc_defines.vh"
// Operation
// - Exactly four modes: normal, slow, power down, green.
// - Any reset enters normal mode executing from high-speed clock.
// - Normal mode runs both oscillators; CPU uses high-speed clock.
// - Clock select 0 gives normal, 1 gives slow on low-speed clock.
// - Slow mode instruction clock is low-speed oscillator divided by four.
// - In slow and green, high-speed oscillators follow only the stop bit.
// - Sleep request 1 enters power down from any mode.
// - Power down stops all three oscillators and execution.
// - Power down wakes on port change or reset, resumes normal.
// - Wake from power down clears sleep request bit.
// - Green request halts execution; current clock oscillator keeps running.
// - Wake from green clears green request bit.
// - Green wakes on port change, wake timer overflow, or reset.
// - Green resumes the mode active before entry.
// - Wake timer keeps counting in green when enabled.
// - Second timer keeps output in green but never wakes.
// - Interrupt enables per mode; all inactive in power down.
// - Stop bit set in normal mode behaves as power down.
// - Mode field: 00 normal, 01 sleep, 10 green, 11 reserved.
// - Stop bit 1 disables selected high-speed source, 0 runs it.
// - Power down wake waits 2048 crystal or 8 RC clocks.
// - Green wake resumes with no stabilisation delay.
module omc_ctrl #(
  parameter WARM_XTAL = `OMC_WARM_XTAL,
  parameter WARM_RC = `OMC_WARM_RC
) (
  input wire mclk_i,
  input wire rst_i,
  input wire reg_wr_i,
  input wire [7:0] reg_wdata_i,
  input wire hosc_is_rc_i,
  input wire use_internal_high_i,
  input wire [7:0] wake_port_i,
  input wire wake_timer_ovf_i,
  input wire wake_timer_enable_i,
  input wire second_timer_enable_i,
  output reg [7:0] reg_rdata_o,
  output reg external_high_osc_en_o,
  output reg internal_high_osc_en_o,
  output reg internal_low_osc_en_o,
  output reg cpu_run_o,
  output reg cpu_clk_slow_o,
  output reg slow_tick_o,
  output reg wake_timer_run_o,
  output reg second_timer_run_o,
  output reg second_timer_wake_en_o,
  output reg int_internal_en_o,
  output reg int_wake_timer_en_o,
  output reg int_external_en_o,
  output reg [1:0] mode_o
);

  //----------------------------------------------------------------
  // States
  //----------------------------------------------------------------
  localparam [2:0] ST_NORMAL = 3'h0;
  localparam [2:0] ST_SLOW = 3'h1;
  localparam [2:0] ST_GREEN = 3'h2;
  localparam [2:0] ST_DOWN = 3'h3;
  localparam [2:0] ST_WARM = 3'h4;
  // Full-width differences, cut to the register widths on purpose
  localparam [31:0] WARM_X_FULL = WARM_XTAL - 1;
  localparam [31:0] WARM_R_FULL = WARM_RC - 1;
  localparam [31:0] DIV_FULL = `OMC_SLOW_DIV - 1;
  localparam [11:0] WARM_X = WARM_X_FULL[11:0];
  localparam [11:0] WARM_R = WARM_R_FULL[11:0];
  localparam [1:0] DIV_TOP = DIV_FULL[1:0];

  reg [2:0] state_r;
  reg [2:0] state_nxt;
  reg stop_r;
  reg slow_r;
  reg sleep_r;
  reg green_r;
  reg green_from_slow_r;
  reg [11:0] warm_r;
  reg [1:0] div_r;
  reg [7:0] port_s1_r;
  reg [7:0] port_s2_r;
  reg [7:0] port_ref_r;
  reg port_chg_r;
  wire wr_sleep;
  wire wr_green;
  reg [2:0] port_fill_r;
  wire timer_wake;
  wire green_wake;
  // Decoded states and transition events
  wire nxt_normal;
  wire nxt_slow;
  wire nxt_green;
  wire nxt_down;
  wire nxt_warm;
  wire nxt_awake;
  wire green_src_slow;
  wire high_run;
  wire ev_pd_wake;
  wire ev_warm_done;
  wire ev_green_entry;
  wire ev_green_exit;
  // Next values of the registered outputs
  reg [7:0] rdata_nxt;
  reg xosc_en_nxt;
  reg iosc_en_nxt;
  reg losc_en_nxt;
  reg cpu_run_nxt;
  reg cpu_slow_nxt;
  reg [1:0] div_nxt;
  reg tick_nxt;
  reg wt_run_nxt;
  reg st_run_nxt;
  reg st_wake_nxt;
  reg int_in_nxt;
  reg int_wt_nxt;
  reg int_ex_nxt;
  reg [1:0] mode_nxt;

  //----------------------------------------------------------------
  // Port change detect
  //----------------------------------------------------------------
  // Two-stage sync; only the second stage is compared
  always @(posedge mclk_i) begin
    if (rst_i) begin
      port_s1_r <= 8'h00;
      port_s2_r <= 8'h00;
      port_ref_r <= 8'h00;
      port_chg_r <= 1'b0;
      port_fill_r <= 3'h0;
    end else begin
      port_s1_r <= wake_port_i;
      port_s2_r <= port_s1_r;
      port_ref_r <= port_s2_r;
      // No compare until the reference holds a real pin sample
      port_fill_r <= {port_fill_r[1:0], 1'b1};
      port_chg_r <= (port_s2_r != port_ref_r) & port_fill_r[2];
    end
  end

  // Reserved code 11 writes neither request
  assign wr_sleep = reg_wdata_i[`OMC_BIT_SLEEP] &
                    ~reg_wdata_i[`OMC_BIT_GREEN];
  assign wr_green = reg_wdata_i[`OMC_BIT_GREEN] &
                    ~reg_wdata_i[`OMC_BIT_SLEEP];

  // Green ends on a pin change or an enabled timer overflow
  assign timer_wake = wake_timer_ovf_i & wake_timer_enable_i;
  assign green_wake = port_chg_r | timer_wake;

  //----------------------------------------------------------------
  // Next state
  //----------------------------------------------------------------
  always @* begin
    state_nxt = state_r;
    case (state_r)
      ST_NORMAL: begin
        if (sleep_r || stop_r) begin
          state_nxt = ST_DOWN;
        end else if (green_r) begin
          state_nxt = ST_GREEN;
        end else if (slow_r) begin
          state_nxt = ST_SLOW;
        end
      end
      ST_SLOW: begin
        if (sleep_r) begin
          state_nxt = ST_DOWN;
        end else if (green_r) begin
          state_nxt = ST_GREEN;
        end else if (!slow_r) begin
          state_nxt = ST_NORMAL;
        end
      end
      ST_GREEN: begin
        if (sleep_r) begin
          state_nxt = ST_DOWN;
        end else if (green_wake) begin
          // No warm-up: the clock never stopped
          state_nxt = green_from_slow_r ? ST_SLOW : ST_NORMAL;
        end
      end
      ST_DOWN: begin
        if (port_chg_r) begin
          state_nxt = ST_WARM;
        end
      end
      ST_WARM: begin
        if (warm_r == 12'h000) begin
          state_nxt = ST_NORMAL;
        end
      end
      default: begin
        state_nxt = ST_NORMAL;
      end
    endcase
  end

  //----------------------------------------------------------------
  // Decoded next state
  //----------------------------------------------------------------
  // One flag per state the machine enters at the coming edge
  assign nxt_normal = (state_nxt == ST_NORMAL);
  assign nxt_slow = (state_nxt == ST_SLOW);
  assign nxt_green = (state_nxt == ST_GREEN);
  assign nxt_down = (state_nxt == ST_DOWN);
  assign nxt_warm = (state_nxt == ST_WARM);
  // Clock present: neither asleep nor warming up
  assign nxt_awake = ~nxt_down & ~nxt_warm;
  // Clock of green: held flag inside green, present state on entry
  assign green_src_slow = (state_r == ST_GREEN) ? green_from_slow_r :
                          (state_r == ST_SLOW);
  // High source: full run in normal and warm-up, stop bit in slow and green, off in power down
  assign high_run = nxt_normal | nxt_warm |
                    ((nxt_slow | nxt_green) & ~stop_r);
  // Transitions that load or clear the control bits
  assign ev_pd_wake = (state_r == ST_DOWN) & nxt_warm;
  assign ev_warm_done = (state_r == ST_WARM) & nxt_normal;
  assign ev_green_entry = (state_r != ST_GREEN) & nxt_green;
  assign ev_green_exit = (state_r == ST_GREEN) & ~nxt_green;

  //----------------------------------------------------------------
  // Control bits, state and warm-up counter
  //----------------------------------------------------------------
  always @(posedge mclk_i) begin
    if (rst_i) begin
      state_r <= ST_NORMAL;
      stop_r <= 1'b0;
      slow_r <= 1'b0;
      sleep_r <= 1'b0;
      green_r <= 1'b0;
      green_from_slow_r <= 1'b0;
      warm_r <= 12'h000;
    end else begin
      state_r <= state_nxt;
      if (reg_wr_i) begin
        stop_r <= reg_wdata_i[`OMC_BIT_STOP];
        slow_r <= reg_wdata_i[`OMC_BIT_SLOW];
      end else if (ev_pd_wake) begin
        stop_r <= 1'b0; // Wake restarts the high clock
      end
      // Hardware clear on wake; a write in the same cycle loses
      if (ev_warm_done) begin
        sleep_r <= 1'b0;
      end else if (reg_wr_i) begin
        sleep_r <= wr_sleep;
      end
      if (ev_green_exit) begin
        green_r <= 1'b0;
      end else if (reg_wr_i) begin
        green_r <= wr_green;
      end
      if (ev_green_entry) begin
        green_from_slow_r <= (state_r == ST_SLOW);
      end
      if (ev_pd_wake) begin
        warm_r <= hosc_is_rc_i ? WARM_R : WARM_X;
      end else if (warm_r != 12'h000) begin
        warm_r <= warm_r - 12'h001;
      end
    end
  end

  //----------------------------------------------------------------
  // Next output values
  //----------------------------------------------------------------
  // Every output is worked out here and registered below
  always @* begin
    // Readback mirrors the held control bits
    rdata_nxt = {3'h0, green_r, sleep_r, slow_r, stop_r, 1'b0};
    xosc_en_nxt = ~use_internal_high_i & high_run;
    iosc_en_nxt = use_internal_high_i & high_run;
    losc_en_nxt = ~nxt_down;
    cpu_run_nxt = nxt_normal | nxt_slow;
    // Green keeps whichever clock the CPU had before entry
    cpu_slow_nxt = nxt_slow | (nxt_green & green_src_slow);
    // Divide by four of the low-speed clock ticks
    div_nxt = (div_r == DIV_TOP) ? 2'h0 : div_r + 2'h1;
    tick_nxt = (div_r == DIV_TOP);
    // Timers stop only while the clock is gone
    wt_run_nxt = wake_timer_enable_i & nxt_awake;
    st_run_nxt = second_timer_enable_i & nxt_awake;
    st_wake_nxt = 1'b0;
    // Interrupt gates per mode
    int_in_nxt = nxt_normal | nxt_slow;
    int_wt_nxt = nxt_normal | nxt_slow | nxt_green;
    int_ex_nxt = nxt_awake;
    // Warm-up still reports sleep; slow mode reports normal
    if (nxt_down || nxt_warm) begin
      mode_nxt = `OMC_MODE_SLEEP;
    end else if (nxt_green) begin
      mode_nxt = `OMC_MODE_GREEN;
    end else begin
      mode_nxt = `OMC_MODE_NORMAL;
    end
  end

  //----------------------------------------------------------------
  // Registered outputs
  //----------------------------------------------------------------
  always @(posedge mclk_i) begin
    if (rst_i) begin
      reg_rdata_o <= `OMC_REG_RESET;
      external_high_osc_en_o <= 1'b0;
      internal_high_osc_en_o <= 1'b0;
      internal_low_osc_en_o <= 1'b0;
      cpu_run_o <= 1'b0;
      cpu_clk_slow_o <= 1'b0;
      slow_tick_o <= 1'b0;
      div_r <= 2'h0;
      wake_timer_run_o <= 1'b0;
      second_timer_run_o <= 1'b0;
      second_timer_wake_en_o <= 1'b0;
      int_internal_en_o <= 1'b0;
      int_wake_timer_en_o <= 1'b0;
      int_external_en_o <= 1'b0;
      mode_o <= `OMC_MODE_NORMAL;
    end else begin
      // Readback and oscillator enables
      reg_rdata_o <= rdata_nxt;
      external_high_osc_en_o <= xosc_en_nxt;
      internal_high_osc_en_o <= iosc_en_nxt;
      internal_low_osc_en_o <= losc_en_nxt;
      // CPU clocking and the tick divider
      cpu_run_o <= cpu_run_nxt;
      cpu_clk_slow_o <= cpu_slow_nxt;
      div_r <= div_nxt;
      slow_tick_o <= tick_nxt;
      // Timers, interrupt gates and mode field
      wake_timer_run_o <= wt_run_nxt;
      second_timer_run_o <= st_run_nxt;
      second_timer_wake_en_o <= st_wake_nxt;
      int_internal_en_o <= int_in_nxt;
      int_wake_timer_en_o <= int_wt_nxt;
      int_external_en_o <= int_ex_nxt;
      mode_o <= mode_nxt;
    end
  end

endmodule // omc_ctrl

// File: tb/omc_ctrl_properties.sv
// Checker of the mode controller port behaviour
`timescale 1ns/10ps
module omc_chk (
  input wire mclk_i,
  input wire rst_i,
  input wire reg_wr_i,
  input wire [7:0] reg_wdata_i,
  input wire wake_timer_ovf_i,
  input wire wake_timer_enable_i,
  input wire [7:0] reg_rdata_o,
  input wire internal_low_osc_en_o,
  input wire cpu_run_o,
  input wire cpu_clk_slow_o,
  input wire slow_tick_o,
  input wire second_timer_wake_en_o,
  input wire int_internal_en_o,
  input wire int_wake_timer_en_o,
  input wire int_external_en_o,
  input wire [1:0] mode_o
);
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (rst_i);
  // Mode sequencing and gating relations
  a_reset_normal: assert property ($fell(rst_i) |=> cpu_run_o &&
    mode_o == 2'h0 && !cpu_clk_slow_o) else $error("no normal mode");
  a_mode_legal: assert property (mode_o != 2'h3)
    else $error("reserved mode code");
  a_sleep_entry: assert property (reg_wr_i &&
    reg_wdata_i[4:3] == 2'h1 |-> ##3 mode_o == 2'h1) else $error("no sleep");
  a_rsvd_ignored: assert property (reg_wr_i &&
    reg_wdata_i[4:3] == 2'h3 && !reg_wdata_i[1] && cpu_run_o |-> ##3
    cpu_run_o) else $error("reserved code halted cpu");
  a_green_halt: assert property (mode_o == 2'h2 |->
    !cpu_run_o && internal_low_osc_en_o) else $error("green gating");
  a_green_ints: assert property (mode_o == 2'h2 |->
    int_wake_timer_en_o && int_external_en_o && !int_internal_en_o)
    else $error("green interrupts");
  a_green_clk_keep: assert property (mode_o == 2'h2 &&
    $past(mode_o) == 2'h0 |-> cpu_clk_slow_o == $past(cpu_clk_slow_o))
    else $error("green changed cpu clock");
  a_pd_quiet: assert property (mode_o == 2'h1 && !cpu_run_o |->
    !int_external_en_o && !int_internal_en_o) else $error("sleep ints");
  a_timer_wake: assert property (mode_o == 2'h2 &&
    wake_timer_ovf_i && wake_timer_enable_i |=> mode_o == 2'h0 && cpu_run_o)
    else $error("no timer wake");
  a_no_tmr_wake: assert property (!second_timer_wake_en_o)
    else $error("second timer wake");
  a_tick_period: assert property (slow_tick_o && cpu_clk_slow_o
    |=> (!slow_tick_o) [*3] ##1 slow_tick_o) else $error("tick period");
  a_sleep_clear: assert property ($past(mode_o) == 2'h1 &&
    mode_o == 2'h0 |-> ##[0:1] !reg_rdata_o[3]) else $error("sleep bit");
  // Main scenarios
  cover property (mode_o == 2'h2 ##1 mode_o == 2'h0);
  cover property (mode_o == 2'h1 ##1 mode_o == 2'h0);
  cover property (slow_tick_o && cpu_clk_slow_o);
endmodule // omc_chk
bind omc_ctrl omc_chk chk_u (.mclk_i(mclk_i), .rst_i(rst_i),
  .reg_wr_i(reg_wr_i), .reg_wdata_i(reg_wdata_i),
  .wake_timer_ovf_i(wake_timer_ovf_i),
  .wake_timer_enable_i(wake_timer_enable_i), .reg_rdata_o(reg_rdata_o),
  .internal_low_osc_en_o(internal_low_osc_en_o), .cpu_run_o(cpu_run_o),
  .cpu_clk_slow_o(cpu_clk_slow_o), .slow_tick_o(slow_tick_o),
  .second_timer_wake_en_o(second_timer_wake_en_o),
  .int_internal_en_o(int_internal_en_o),
  .int_wake_timer_en_o(int_wake_timer_en_o),
  .int_external_en_o(int_external_en_o), .mode_o(mode_o));

// File: tb/omc_far_model.sv
// Wake pins and wake timer beside the controller
`timescale 1ns/10ps
module omc_far_model (
  input wire mclk_i,
  input wire run_i,
  input wire fire_i,
  input wire kick_i,
  output reg ovf_o = 1'b0,
  output reg [7:0] port_o = 8'hA5
);
  reg [2:0] cnt_r = 3'h0;
  // Timer counts only while allowed to run; pin flips on a kick
  always @(posedge mclk_i) begin
    cnt_r <= (run_i && fire_i) ? cnt_r + 3'h1 : 3'h0;
    ovf_o <= run_i && fire_i && (cnt_r == 3'h5);
    if (kick_i) port_o <= port_o ^ 8'h01;
  end
endmodule // omc_far_model

// File: tb/omc_ctrl_tb.sv
// Self-checking bench of the operating mode controller
`timescale 1ns/10ps
module omc_ctrl_tb;
  localparam int WX = 16;
  logic mclk = 1'b0, rst = 1'b1, reg_wr = 1'b0, rc = 1'b1, ih = 1'b0;
  logic wte = 1'b0, ste = 1'b0, fire = 1'b0, kick = 1'b0;
  logic [7:0] wd = 8'h00, rdata, port;
  logic xo, io, lo, run, slw, tick, wtr, str, ovf, iie, iwe, iee, stwe;
  logic [1:0] mode;
  int error_cnt = 0, n_checks = 0;
  wire [7:0] st = {1'b0, run, slw, xo, io, lo, mode};
  wire [7:0] ints = {5'h00, iie, iwe, iee};
  always #5 mclk = ~mclk;
  omc_ctrl #(.WARM_XTAL(WX), .WARM_RC(8)) dut_u (.mclk_i(mclk), .rst_i(rst),
    .reg_wr_i(reg_wr), .reg_wdata_i(wd), .hosc_is_rc_i(rc),
    .use_internal_high_i(ih), .wake_port_i(port), .wake_timer_ovf_i(ovf),
    .wake_timer_enable_i(wte), .second_timer_enable_i(ste),
    .reg_rdata_o(rdata), .external_high_osc_en_o(xo),
    .internal_high_osc_en_o(io), .internal_low_osc_en_o(lo),
    .cpu_run_o(run), .cpu_clk_slow_o(slw), .slow_tick_o(tick),
    .wake_timer_run_o(wtr), .second_timer_run_o(str),
    .second_timer_wake_en_o(stwe), .int_internal_en_o(iie),
    .int_wake_timer_en_o(iwe), .int_external_en_o(iee), .mode_o(mode));
  omc_far_model far_u (.mclk_i(mclk), .run_i(wtr), .fire_i(fire),
    .kick_i(kick), .ovf_o(ovf), .port_o(port));
  task automatic chk(input string nm, input logic [7:0] e, g);
    n_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("ERROR %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] d);
    @(negedge mclk);
    reg_wr = 1'b1;
    wd = d;
    @(negedge mclk);
    reg_wr = 1'b0;
    repeat (3) @(negedge mclk);
  endtask
  task automatic wake(output int n);
    kick = 1'b1;
    @(negedge mclk);
    kick = 1'b0;
    n = 0;
    while (run !== 1'b1 && n < 5000) begin
      @(negedge mclk);
      n++;
    end
    // Readback settles one edge after the mode
    @(negedge mclk);
  endtask
  task automatic t_green;
    int n;
    ih = 1'b1;
    wte = 1'b1;
    ste = 1'b1;
    wr(8'h04);
    chk("st", 8'h6C, st);
    wr(8'h06);
    chk("st", 8'h64, st);
    while (tick !== 1'b1) @(negedge mclk);
    n = 0;
    do begin
      @(negedge mclk);
      n++;
    end while (tick !== 1'b1 && n < 9);
    chk("tick", 8'h04, n[7:0]);
    wr(8'h16);
    chk("grn", 8'h16, {3'h0, slw, run, lo, mode});
    chk("ints", 8'h03, ints);
    chk("tmr", 8'h06, {5'h00, wtr, str, stwe});
    fire = 1'b1;
    repeat (12) @(negedge mclk);
    fire = 1'b0;
    chk("st", 8'h64, st);
    chk("rd", 8'h06, rdata);
    wr(8'h00);
    chk("st", 8'h4C, st);
    wr(8'h10);
    wake(n);
    chk("st", 8'h4C, st);
    chk("rd", 8'h00, rdata);
  endtask
  task automatic t_other;
    int n;
    ih = 1'b0;
    wr(8'h18);
    chk("st", 8'h54, st);
    chk("rd", 8'h00, rdata & 8'h18);
    wr(8'h02);
    chk("run", 8'h00, {7'h00, run});
    wake(n);
    chk("st", 8'h54, st);
    chk("rd", 8'h00, rdata);
  endtask
  task automatic t_sleep(input logic r, input int w);
    int n;
    rc = r;
    wr(8'h08);
    chk("st", 8'h01, st);
    chk("ints", 8'h00, ints);
    chk("tmr", 8'h00, {5'h00, wtr, str, stwe});
    wake(n);
    chk("warm", 8'h01, {7'h00, n >= w && n <= w + 8});
    chk("st", 8'h54, st);
    chk("rd", 8'h00, rdata);
  endtask
  task automatic give_verdict;
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // Main sequence
  initial begin
    repeat (12) @(negedge mclk);
    rst = 1'b0;
    repeat (2) @(negedge mclk);
    chk("st", 8'h54, st);
    chk("ints", 8'h07, ints);
    t_green;
    t_other;
    t_sleep(1'b1, 8);
    t_sleep(1'b0, WX);
    give_verdict;
  end
  // Watchdog
  initial begin
    #500000;
    error_cnt++;
    give_verdict;
  end
endmodule // omc_ctrl_tb
